// file: core/cidc_map.vh
// constants and register map for the init/status pin control block
// Summary of operation
// - after power-on or program-pin reset the block drives the init/status pin low while memory clears.
// - once the pin has been seen high, a later external low is no longer a delay request.
// - after mode sampling the pin is an open-drain active-low error flag for configuration or enabled readback CRC errors.
// - the pin reads 0 on CRC or device-id error with done low, or readback CRC error with done high and checking on; else 1.
// - with upset detection and its pin-flag control bit both enabled the block may pull the pin low on a readback CRC mismatch.
// - an internal status bit shows whether the init/status signal has been released internally.
// - a three-bit status field returns the live mode-pin values when status is read.
// - the three flash-select pins are captured into a status field when the pin goes high.
`ifndef CIDC_MAP_VH
`define CIDC_MAP_VH

`define CIDC_ADDR_W        4
`define CIDC_REG_STATUS    4'h0
`define CIDC_REG_CTRL      4'h1
`define CIDC_REG_IRQ_STAT  4'h2
`define CIDC_REG_IRQ_MASK  4'h3

// control register fields
`define CIDC_CTRL_RB_EN    0
`define CIDC_CTRL_UPSET_EN 1
`define CIDC_CTRL_UPSET_PIN 2
`define CIDC_CTRL_RST      8'h00

// status register fields
`define CIDC_ST_RELEASED   0
`define CIDC_ST_PIN        1
`define CIDC_ST_SAMPLED    2
`define CIDC_ST_ERR        3
`define CIDC_ST_MODE_LO    4
`define CIDC_ST_FS_LO      8

// interrupt events
`define CIDC_IRQ_W         4
`define CIDC_EV_RELEASE    0
`define CIDC_EV_SAMPLED    1
`define CIDC_EV_CFG_ERR    2
`define CIDC_EV_RB_ERR     3

// memory clear time
`define CIDC_CLEAR_NS      1000
`define CIDC_CLK_NS        10
`define CIDC_CLEAR_CYC     ((`CIDC_CLEAR_NS + `CIDC_CLK_NS - 1) / `CIDC_CLK_NS)
`define CIDC_CNT_W         8

`endif

// file: core/cidc_sync.v
// two-flop synchroniser vector for pin inputs
`timescale 1ns/10ps
`default_nettype none
module cidc_sync #(
	parameter W = 1
) (
	// clock and reset
	input  wire         sys_clk_i,
	input  wire         sys_rst_i,
	// data
	input  wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// first stage feeds only the second stage
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			meta_ff <= {W{1'b1}};
			sync_ff <= {W{1'b1}};
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;
endmodule // cidc_sync
`default_nettype wire

// file: core/cidc_init_ctrl.v
// init/status pin control with status registers and interrupt
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "cidc_map.vh"
module cidc_init_ctrl (
	// clock and reset
	input  wire                   sys_clk_i,
	input  wire                   sys_rst_i,
	// program-pin reset request, low active
	input  wire                   prog_n_i,
	// open-drain init/status pin
	input  wire                   init_pin_i,
	output wire                   init_pin_o,
	output wire                   init_pin_oe_o,
	// sampled pins
	input  wire [2:0]             mode_pins_i,
	input  wire [2:0]             flash_select_pins_i,
	// configuration engine
	input  wire                   done_i,
	input  wire                   crc_err_i,
	input  wire                   device_id_code_err_i,
	input  wire                   rb_crc_err_i,
	output wire                   mode_sampled_o,
	output wire [2:0]             mode_value_o,
	// register port
	input  wire [`CIDC_ADDR_W-1:0] reg_addr_i,
	input  wire [7:0]             reg_wdata_i,
	input  wire                   reg_wr_i,
	input  wire                   reg_rd_i,
	output wire [15:0]            reg_rdata_o,
	// interrupt
	output wire                   irq_o
);
	localparam [3:0] ST_CLEAR = 4'h1;
	localparam [3:0] ST_WAIT  = 4'h2;
	localparam [3:0] ST_SAMP  = 4'h4;
	localparam [3:0] ST_RUN   = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	wire       pin_s;
	wire       prog_n_s;
	wire [2:0] mode_s;
	wire [2:0] fs_s;

	cidc_sync #(.W(8)) u_sync (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   ({init_pin_i, prog_n_i, mode_pins_i, flash_select_pins_i}),
		.sync_o    ({pin_s, prog_n_s, mode_s, fs_s})
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer
	reg [3:0]             state_ff;
	reg [3:0]             nxt_state;
	reg [`CIDC_CNT_W-1:0] clr_cnt_ff;
	reg [`CIDC_CNT_W-1:0] nxt_clr_cnt;
	reg [2:0]             mode_ff;
	reg [2:0]             fs_snap_ff;
	reg                   cfg_err_ff;
	reg                   rb_err_ff;
	reg [7:0]             ctrl_ff;
	reg [`CIDC_IRQ_W-1:0] irq_stat_ff;
	reg [`CIDC_IRQ_W-1:0] irq_mask_ff;
	reg [15:0]            rdata_ff;

	wire clear_done = (clr_cnt_ff == `CIDC_CLEAR_CYC - 1);
	wire released   = (state_ff != ST_CLEAR);

	always @* begin
		nxt_state   = state_ff;
		nxt_clr_cnt = clr_cnt_ff;
		case (state_ff)
			ST_CLEAR: begin
				// hold low for the whole clear time
				if (clear_done) begin
					nxt_state = ST_WAIT;
				end else begin
					nxt_clr_cnt = clr_cnt_ff + 1'b1;
				end
			end
			ST_WAIT: begin
				// pin is an input here; an external low stalls the sequence
				if (pin_s) begin
					nxt_state = ST_SAMP;
				end
			end
			ST_SAMP: begin
				nxt_state = ST_RUN;
			end
			ST_RUN: begin
				// a later external low no longer delays anything
				nxt_state = ST_RUN;
			end
			default: begin
				nxt_state = ST_CLEAR;
			end
		endcase
		if (!prog_n_s) begin
			nxt_state   = ST_CLEAR;
			nxt_clr_cnt = {`CIDC_CNT_W{1'b0}};
		end
	end

	wire rb_on    = ctrl_ff[`CIDC_CTRL_RB_EN] |
	                (ctrl_ff[`CIDC_CTRL_UPSET_EN] & ctrl_ff[`CIDC_CTRL_UPSET_PIN]);
	wire cfg_ev   = (state_ff == ST_RUN) & !done_i & (crc_err_i | device_id_code_err_i);
	wire rb_ev    = (state_ff == ST_RUN) & done_i & rb_crc_err_i & rb_on;
	wire sampling = (state_ff == ST_SAMP);

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state_ff   <= ST_CLEAR;
			clr_cnt_ff <= {`CIDC_CNT_W{1'b0}};
			mode_ff    <= 3'h0;
			fs_snap_ff <= 3'h0;
			cfg_err_ff <= 1'b0;
			rb_err_ff  <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			clr_cnt_ff <= nxt_clr_cnt;
			if (sampling) begin
				mode_ff <= mode_s;
			end
			if (state_ff == ST_WAIT && pin_s) begin
				fs_snap_ff <= fs_s;
			end
			// errors stay until the next reset/clear
			if (state_ff == ST_CLEAR) begin
				cfg_err_ff <= 1'b0;
				rb_err_ff  <= 1'b0;
			end else begin
				if (cfg_ev) begin
					cfg_err_ff <= 1'b1;
				end
				if (rb_ev) begin
					rb_err_ff <= 1'b1;
				end
			end
		end
	end

	// open drain: only ever drive low
	wire err_any = (cfg_err_ff & !done_i) | (rb_err_ff & done_i & rb_on);
	assign init_pin_o    = 1'b0;
	assign init_pin_oe_o = (state_ff == ST_CLEAR) | ((state_ff == ST_RUN) & err_any);
	assign mode_sampled_o = (state_ff == ST_RUN);
	assign mode_value_o   = mode_ff;

	////////////////////////////////////////////////////////////////////////
	// registers and interrupt
	wire [`CIDC_IRQ_W-1:0] ev;
	assign ev[`CIDC_EV_RELEASE] = (state_ff == ST_CLEAR) & (nxt_state == ST_WAIT);
	assign ev[`CIDC_EV_SAMPLED] = sampling;
	assign ev[`CIDC_EV_CFG_ERR] = cfg_ev;
	assign ev[`CIDC_EV_RB_ERR]  = rb_ev;

	wire stat_clr_wr = reg_wr_i & (reg_addr_i == `CIDC_REG_IRQ_STAT);

	genvar gi;
	generate
		for (gi = 0; gi < `CIDC_IRQ_W; gi = gi + 1) begin : g_irq
			// set wins over a clear in the same cycle
			always @(posedge sys_clk_i) begin
				if (sys_rst_i) begin
					irq_stat_ff[gi] <= 1'b0;
				end else if (ev[gi]) begin
					irq_stat_ff[gi] <= 1'b1;
				end else if (stat_clr_wr & reg_wdata_i[gi]) begin
					irq_stat_ff[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ctrl_ff     <= `CIDC_CTRL_RST;
			irq_mask_ff <= {`CIDC_IRQ_W{1'b0}};
		end else if (reg_wr_i) begin
			if (reg_addr_i == `CIDC_REG_CTRL) begin
				ctrl_ff <= reg_wdata_i;
			end
			if (reg_addr_i == `CIDC_REG_IRQ_MASK) begin
				irq_mask_ff <= reg_wdata_i[`CIDC_IRQ_W-1:0];
			end
		end
	end

	wire [15:0] status_word = {5'h00, fs_snap_ff, 1'b0, mode_s,
	                           rb_err_ff | cfg_err_ff, mode_sampled_o, pin_s, released};

	reg [15:0] rd_mux;
	always @* begin
		case (reg_addr_i)
			// mode field is the live pin value at read time
			`CIDC_REG_STATUS:   rd_mux = status_word;
			`CIDC_REG_CTRL:     rd_mux = {8'h00, ctrl_ff};
			`CIDC_REG_IRQ_STAT: rd_mux = {12'h000, irq_stat_ff};
			`CIDC_REG_IRQ_MASK: rd_mux = {12'h000, irq_mask_ff};
			default:            rd_mux = 16'h0000;
		endcase
	end

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rdata_ff <= 16'h0000;
		end else if (reg_rd_i) begin
			rdata_ff <= rd_mux;
		end else begin
			rdata_ff <= 16'h0000;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign irq_o       = |(irq_stat_ff & irq_mask_ff);
endmodule // cidc_init_ctrl
`default_nettype wire

// file: verification/cidc_board.sv
// board side of the open-drain init/status wire
`timescale 1ns/10ps
`default_nettype none
module cidc_board (
	// device drive and board hold
	input  wire logic oe_i,
	input  wire logic hold_i,
	// resolved wire level
	output wire logic wire_o
);
	// pull-up wins only while nobody pulls low
	assign wire_o = !oe_i && !hold_i;
endmodule // cidc_board
`default_nettype wire

// file: verification/cidc_init_ctrl_props.sv
// port assertions for the init/status pin controller
`timescale 1ns/10ps
`default_nettype none
module cidc_props (
	input wire logic        sys_clk_i,
	input wire logic        sys_rst_i,
	input wire logic        prog_n_i,
	input wire logic        init_pin_i,
	input wire logic        init_pin_oe_o,
	input wire logic        done_i,
	input wire logic        crc_err_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic        mode_sampled_o,
	input wire logic [2:0]  mode_value_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence cfg_fault;
		mode_sampled_o && crc_err_i && !done_i ##1 !done_i;
	endsequence
	clear_hold_a: assert property ($fell(sys_rst_i) |-> init_pin_oe_o [*8])
		else $error("pin released too soon after reset");
	// four cycles cover the two-flop lag on the pin
	delay_hold_a: assert property ((!init_pin_i && !mode_sampled_o) [*4] |=> !mode_sampled_o)
		else $error("sampling went on while pin held low");
	late_low_a: assert property ((mode_sampled_o && prog_n_i) [*3] |=> mode_sampled_o)
		else $error("run state left without restart");
	cfg_flag_a: assert property (cfg_fault |-> init_pin_oe_o)
		else $error("config error not flagged on pin");
	clean_release_a: assert property ($rose(mode_sampled_o) |-> !init_pin_oe_o)
		else $error("pin low at sampling with no error");
	read_quiet_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
		else $error("read data outside read slot");
	run_after_pin_a: assert property ($rose(mode_sampled_o) |-> $past(init_pin_i))
		else $error("mode sampled while pin low");
	mode_keep_a: assert property (mode_sampled_o && $past(mode_sampled_o) |-> $stable(mode_value_o))
		else $error("captured mode changed in run");
endmodule // cidc_props
bind cidc_init_ctrl cidc_props i_props (
	.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .prog_n_i(prog_n_i),
	.init_pin_i(init_pin_i), .init_pin_oe_o(init_pin_oe_o), .done_i(done_i),
	.crc_err_i(crc_err_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.mode_sampled_o(mode_sampled_o), .mode_value_o(mode_value_o));
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the init/status pin controller
`timescale 1ns/10ps
`default_nettype none
`include "cidc_map.vh"
module tb;
	logic        sys_clk_i = 0, sys_rst_i = 1, prog_n_i = 1, hold = 1, done_i = 0;
	logic        crc = 0, idc = 0, rbe = 0, rd = 0, wr = 0;
	logic [2:0]  mode = 0, fs = 0;
	logic [3:0]  addr = 0;
	logic [7:0]  wdat = 0;
	logic [15:0] got;
	wire         pin, oe, samp, irq;
	wire  [2:0]  mval;
	wire  [15:0] rdat;
	int          bad_count = 0, cmp_count = 0, n, k, cf, rf;
	int          ctl[6] = '{0, 0, 1, 6, 2, 0};
	always #5 sys_clk_i = !sys_clk_i;
	cidc_board i_board (.oe_i(oe), .hold_i(hold), .wire_o(pin));
	cidc_init_ctrl i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .prog_n_i(prog_n_i),
		.init_pin_i(pin), .init_pin_o(), .init_pin_oe_o(oe), .mode_pins_i(mode),
		.flash_select_pins_i(fs), .done_i(done_i), .crc_err_i(crc), .device_id_code_err_i(idc),
		.rb_crc_err_i(rbe), .mode_sampled_o(samp), .mode_value_o(mval), .reg_addr_i(addr),
		.reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .irq_o(irq));
	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (e !== g) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdat <= d;
		@(posedge sys_clk_i);
		wr <= 0;
		rd <= 0;
		#1 got = rdat;
	endtask
	// restart by reset or program pin, board delays release for a while
	task automatic boot(input logic by_prog);
		@(posedge sys_clk_i);
		if (by_prog)
			prog_n_i <= 0;
		hold <= 1;
		done_i <= 0;
		repeat (5) @(posedge sys_clk_i);
		prog_n_i <= 1;
		sys_rst_i <= 0;
		mode <= $urandom;
		fs <= $urandom;
		n = 0;
		cyc(1);
		while (oe === 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		chk("clear len", 1, n >= `CIDC_CLEAR_CYC - 1 && n <= `CIDC_CLEAR_CYC + 3);
		cyc(30);
		chk("held wait", 0, samp);
		@(posedge sys_clk_i) hold <= 0;
		n = 0;
		while (samp !== 1'b1 && n < 50) begin
			cyc(1);
			n++;
		end
		if (n == 50) begin
			bad_count++;
			$display("[FAIL] sample wait expected %h seen %h", 1'b1, samp);
			stop_test();
		end
		chk("mode cap", mode, mval);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		k = $urandom(14603);
		boot(0);
		bus(0, `CIDC_REG_STATUS, 0);
		chk("fs snap", fs, got[10:8]);
		chk("released", 1, got[0]);
		@(posedge sys_clk_i) mode <= $urandom;
		cyc(4);
		bus(0, `CIDC_REG_STATUS, 0);
		chk("mode live", mode, got[6:4]);
		@(posedge sys_clk_i) hold <= 1;
		cyc(20);
		chk("late low", 1, samp);
		@(posedge sys_clk_i) hold <= 0;
		bus(0, 4'h7, 8'h00);
		chk("unmapped", 0, got);
		for (k = 0; k < 6; k++) begin
			boot(1);
			bus(1, `CIDC_REG_CTRL, ctl[k]);
			bus(1, `CIDC_REG_IRQ_MASK, 8'h0C);
			bus(1, `CIDC_REG_IRQ_STAT, 8'h0F);
			@(posedge sys_clk_i);
			done_i <= k > 1;
			crc <= k == 0 || k == 5;
			idc <= k == 1;
			rbe <= k > 1 && k < 5;
			@(posedge sys_clk_i);
			crc <= 0;
			idc <= 0;
			rbe <= 0;
			cyc(2);
			cf = k < 2;
			rf = k > 1 && k < 5 && ((ctl[k] & 1) == 1 || (ctl[k] & 6) == 6);
			chk("pin flag", cf || rf, oe);
			chk("irq", cf || rf, irq);
			bus(0, `CIDC_REG_IRQ_STAT, 0);
			chk("irq stat", cf * 4 + rf * 8, got & 16'h000C);
			bus(0, `CIDC_REG_STATUS, 0);
			chk("err bit", cf || rf, got[3]);
			chk("pin bit", !(cf || rf), got[1]);
			bus(1, `CIDC_REG_IRQ_STAT, 8'h0C);
			cyc(1);
			chk("irq clr", 0, irq);
		end
		stop_test();
	end
endmodule // tb
`default_nettype wire
